// file: core/cpr_pkg.sv
// Constants shared by the configuration readout control block.
// Assumes a 20 MHz system clock and an external configuration clock pin.
package cpr_pkg;
    localparam int SYS_PERIOD_NS  = 50;
    localparam int POR_TIME_NS    = 1000;
    localparam int PULSE_TIME_NS  = 500;
    // Least times round up to whole cycles
    localparam int POR_CYCLES     = (POR_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int PULSE_CYCLES   = (PULSE_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int OSC_DIV        = 4;
    localparam int CNT_W          = 5;

    localparam int DATA_W         = 8;
    localparam int UPPER_W        = 7;
    localparam int ADDR_W         = 8;
    localparam int MEM_WORDS      = 256;
    localparam int BIT_W          = 3;
    localparam int REV_W          = 2;
    localparam int REV_NUM        = 4;
    localparam logic [ADDR_W-1:0] REV_START [REV_NUM] = '{8'h00, 8'h40, 8'h80, 8'hc0};

    // Positions in the synchronised pin vector
    localparam int PIN_CS_N       = 0;
    localparam int PIN_OE_RESET   = 1;
    localparam int PIN_CFG_PULSE  = 2;
    localparam int PIN_BUSY       = 3;
    localparam int PIN_ISP        = 4;
    localparam int PIN_CLAMP      = 5;
    localparam int PIN_SEL_EXT    = 6;
    localparam int PIN_PARALLEL   = 7;
    localparam int PIN_REV        = 8;
    localparam int PIN_W          = 10;
endpackage

// file: core/cpr_link_edge.sv
// Link-side edge catcher: toggles on each external clock rising edge.
// Assumes the external clock may stop; only the toggle level crosses.
`timescale 1ns/1ns
`default_nettype none
module cpr_link_edge (
    input  wire logic link_clk,
    input  wire logic clk_sys,
    input  wire logic arst_n,
    output logic      tick
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } cpr_edge_t;

    logic      toggle;
    cpr_edge_t st;
    cpr_edge_t next_st;

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
        end
    end

    // First stage feeds only the second; the edge compare looks at later stages
    always_comb begin
        next_st    = st;
        next_st.s1 = toggle;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.s2 ^ st.s3;
endmodule // cpr_link_edge
`default_nettype wire

// file: core/cpr_readout.sv
// Readout control of a configuration memory streaming data to an FPGA.
// Assumes pins other than JTAG_RELOAD and the memory write port asynchronous to CLK_SYS; CFG_CLK is the external clock.
`timescale 1ns/1ns
`default_nettype none
module cpr_readout (
    input  wire logic                        CLK_SYS,
    input  wire logic                        ARST_N,
    input  wire logic                        CFG_CLK,
    input  wire logic                        CHIP_SELECT_N,
    input  wire logic                        OE_RESET_IN,
    output logic                             OE_RESET_OUT,
    output logic                             OE_RESET_OE,
    input  wire logic                        CONFIG_PULSE_N_IN,
    output logic                             CONFIG_PULSE_N_OUT,
    output logic                             CONFIG_PULSE_N_OE,
    input  wire logic                        BUSY,
    input  wire logic                        IN_SYSTEM_PROGRAM_MODE,
    input  wire logic                        PINS_CLAMPED,
    input  wire logic                        CLOCK_SELECT_EXTERNAL,
    input  wire logic                        PARALLEL_MODE,
    input  wire logic [cpr_pkg::REV_W-1:0]   REVISION_SELECT,
    input  wire logic                        JTAG_RELOAD,
    input  wire logic                        MEM_WR_EN,
    input  wire logic [cpr_pkg::ADDR_W-1:0]  MEM_WR_ADDR,
    input  wire logic [cpr_pkg::DATA_W-1:0]  MEM_WR_DATA,
    output logic                             SERIAL_DATA_BIT,
    output logic                             SERIAL_DATA_BIT_OE,
    output logic [cpr_pkg::UPPER_W-1:0]      UPPER_PARALLEL_DATA_BITS,
    output logic [cpr_pkg::UPPER_W-1:0]      UPPER_PARALLEL_DATA_BITS_OE,
    output logic                             FORWARDED_CONFIG_CLOCK,
    output logic                             FORWARDED_CONFIG_CLOCK_OE,
    output logic                             STANDBY
);
    typedef struct packed {
        logic [cpr_pkg::PIN_W-1:0]  pin_s1;
        logic [cpr_pkg::PIN_W-1:0]  pin_s2;
        logic [cpr_pkg::CNT_W-1:0]  por_cnt;
        logic                       por_done;
        logic [cpr_pkg::CNT_W-1:0]  pulse_cnt;
        logic [cpr_pkg::CNT_W-1:0]  osc_cnt;
        logic [cpr_pkg::ADDR_W-1:0] addr;
        logic [cpr_pkg::BIT_W-1:0]  bit_idx;
        logic [cpr_pkg::DATA_W-1:0] data;
        logic                       ser_bit;
        logic [cpr_pkg::REV_W-1:0]  rev;
        logic                       cf_prev;
        logic                       clk_out;
    } cpr_state_t;

    localparam logic [cpr_pkg::CNT_W-1:0] POR_LAST   = cpr_pkg::CNT_W'(cpr_pkg::POR_CYCLES - 1);
    localparam logic [cpr_pkg::CNT_W-1:0] PULSE_LEN  = cpr_pkg::CNT_W'(cpr_pkg::PULSE_CYCLES);
    localparam logic [cpr_pkg::CNT_W-1:0] OSC_LAST   = cpr_pkg::CNT_W'(cpr_pkg::OSC_DIV - 1);
    localparam logic [cpr_pkg::BIT_W-1:0] BIT_LAST   = cpr_pkg::BIT_W'(cpr_pkg::DATA_W - 1);

    logic [cpr_pkg::DATA_W-1:0] mem [cpr_pkg::MEM_WORDS];
    cpr_state_t                 st;
    cpr_state_t                 next_st;
    logic                       ext_tick;
    logic                       int_tick;
    logic                       src_tick;
    logic                       cs_n;
    logic                       oe_in;
    logic                       cf_in;
    logic                       busy;
    logic                       isp;
    logic                       clamp;
    logic                       sel_ext;
    logic                       par;
    logic [cpr_pkg::REV_W-1:0]  rev_sel;
    logic                       advance;
    logic                       cf_rise;
    logic                       active;
    logic                       data_en;
    logic [cpr_pkg::PIN_W-1:0]  pins_raw;

    cpr_link_edge u_link_edge (
        .link_clk (CFG_CLK),
        .clk_sys  (CLK_SYS),
        .arst_n   (ARST_N),
        .tick     (ext_tick)
    );

    // Programming path writes the stored bitstream; no reset on the array
    always_ff @(posedge CLK_SYS) begin
        if (MEM_WR_EN) begin
            mem[MEM_WR_ADDR] <= MEM_WR_DATA;
        end
    end

    assign pins_raw = {REVISION_SELECT, PARALLEL_MODE, CLOCK_SELECT_EXTERNAL, PINS_CLAMPED,
                       IN_SYSTEM_PROGRAM_MODE, BUSY, CONFIG_PULSE_N_IN, OE_RESET_IN,
                       CHIP_SELECT_N};

    assign cs_n    = st.pin_s2[cpr_pkg::PIN_CS_N];
    assign oe_in   = st.pin_s2[cpr_pkg::PIN_OE_RESET];
    assign cf_in   = st.pin_s2[cpr_pkg::PIN_CFG_PULSE];
    assign busy    = st.pin_s2[cpr_pkg::PIN_BUSY];
    assign isp     = st.pin_s2[cpr_pkg::PIN_ISP];
    assign clamp   = st.pin_s2[cpr_pkg::PIN_CLAMP];
    assign sel_ext = st.pin_s2[cpr_pkg::PIN_SEL_EXT];
    assign par     = st.pin_s2[cpr_pkg::PIN_PARALLEL];
    assign rev_sel = st.pin_s2[cpr_pkg::PIN_REV +: cpr_pkg::REV_W];

    assign int_tick = (st.osc_cnt == OSC_LAST);
    assign src_tick = sel_ext ? ext_tick : int_tick;
    assign active   = !cs_n && oe_in;
    // Busy stalls only in parallel mode
    assign advance  = src_tick && active && cf_in && !(par && busy) && st.por_done;
    assign cf_rise  = cf_in && !st.cf_prev;

    always_comb begin
        next_st        = st;
        next_st.pin_s1 = pins_raw;
        next_st.pin_s2 = st.pin_s1;
        next_st.cf_prev = cf_in;
        next_st.osc_cnt = int_tick ? '0 : st.osc_cnt + 1'b1;
        next_st.clk_out = advance;
        if (!st.por_done) begin
            next_st.por_cnt = st.por_cnt + 1'b1;
            if (st.por_cnt == POR_LAST) begin
                next_st.por_done = 1'b1;
            end
        end
        if (JTAG_RELOAD && st.pulse_cnt == '0) begin
            next_st.pulse_cnt = PULSE_LEN;
        end else if (st.pulse_cnt != '0) begin
            next_st.pulse_cnt = st.pulse_cnt - 1'b1;
        end
        if (cf_rise) begin
            next_st.rev = rev_sel;
        end
        if (!active) begin
            next_st.addr    = cpr_pkg::REV_START[next_st.rev];
            next_st.bit_idx = '0;
        end else if (cf_rise) begin
            next_st.addr    = cpr_pkg::REV_START[next_st.rev];
            next_st.bit_idx = '0;
        end else if (advance) begin
            if (par || st.bit_idx == BIT_LAST) begin
                next_st.addr    = st.addr + 1'b1;
                next_st.bit_idx = '0;
            end else begin
                next_st.bit_idx = st.bit_idx + 1'b1;
            end
        end
        next_st.data    = mem[next_st.addr];
        // Serial stream leaves the most significant bit first
        next_st.ser_bit = par ? next_st.data[0] : next_st.data[BIT_LAST - next_st.bit_idx];
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Unclamped ISP floats data; clamped pins keep their drive
    assign data_en = active && !(isp && !clamp);

    assign SERIAL_DATA_BIT             = st.ser_bit;
    assign SERIAL_DATA_BIT_OE          = data_en;
    assign UPPER_PARALLEL_DATA_BITS    = st.data[cpr_pkg::DATA_W-1:1];
    assign UPPER_PARALLEL_DATA_BITS_OE = {cpr_pkg::UPPER_W{data_en && par}};
    assign FORWARDED_CONFIG_CLOCK      = st.clk_out;
    assign FORWARDED_CONFIG_CLOCK_OE   = active;
    assign OE_RESET_OUT                = 1'b0;
    assign OE_RESET_OE                 = !st.por_done;
    assign CONFIG_PULSE_N_OUT          = 1'b0;
    assign CONFIG_PULSE_N_OE           = (st.pulse_cnt != '0);
    assign STANDBY                     = cs_n;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);

    property p_isp_upper;
        (isp && !clamp) |-> (UPPER_PARALLEL_DATA_BITS_OE == '0);
    endproperty
    a_isp_upper: assert property (p_isp_upper) else $error("upper bits driven in ISP");

    property p_serial_upper;
        !par |-> (UPPER_PARALLEL_DATA_BITS_OE == '0);
    endproperty
    a_serial_upper: assert property (p_serial_upper) else $error("upper bits in serial");

    property p_src_select;
        (active && !cf_rise && ((sel_ext && !ext_tick) || (!sel_ext && !int_tick)))
            |=> ($stable(st.addr) && $stable(st.bit_idx));
    endproperty
    a_src_select: assert property (p_src_select) else $error("step without source tick");

    property p_advance;
        (advance && par && !cf_rise) |=> (st.addr == cpr_pkg::ADDR_W'($past(st.addr) + 1));
    endproperty
    a_advance: assert property (p_advance) else $error("counter did not step");

    property p_oe_reset;
        (!oe_in && !cf_rise) |-> !FORWARDED_CONFIG_CLOCK_OE ##1
            (st.addr == cpr_pkg::REV_START[st.rev] && st.bit_idx == '0);
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("reset pin not obeyed");

    property p_por;
        $fell(OE_RESET_OE) |-> ($past(st.por_cnt) == POR_LAST);
    endproperty
    a_por: assert property (p_por) else $error("reset pin drive wrong");

    property p_standby;
        STANDBY |-> (!SERIAL_DATA_BIT_OE && !FORWARDED_CONFIG_CLOCK_OE
            && UPPER_PARALLEL_DATA_BITS_OE == '0);
    endproperty
    a_standby: assert property (p_standby) else $error("no standby");

    property p_cs_reset;
        (cs_n && !cf_rise) |-> !SERIAL_DATA_BIT_OE ##1 (st.addr == cpr_pkg::REV_START[st.rev]);
    endproperty
    a_cs_reset: assert property (p_cs_reset) else $error("chip select reset failed");

    property p_reload;
        (JTAG_RELOAD && !CONFIG_PULSE_N_OE) |=> CONFIG_PULSE_N_OE [*8] ##1
            CONFIG_PULSE_N_OE [*2] ##1 !CONFIG_PULSE_N_OE;
    endproperty
    a_reload: assert property (p_reload) else $error("reload pulse too short");

    property p_rev_sample;
        cf_rise |=> (st.rev == $past(rev_sel));
    endproperty
    a_rev_sample: assert property (p_rev_sample) else $error("revision not sampled");

    property p_rev_load;
        (cf_rise && active) |=> (st.addr == cpr_pkg::REV_START[st.rev] && st.bit_idx == '0);
    endproperty
    a_rev_load: assert property (p_rev_load) else $error("start address not loaded");

    property p_isp_serial;
        (isp && !clamp) |-> !SERIAL_DATA_BIT_OE;
    endproperty
    a_isp_serial: assert property (p_isp_serial) else $error("lowest bit driven in ISP");

    property p_busy;
        (par && busy && active && !cf_rise && !MEM_WR_EN) |=> ($stable(st.data) && $stable(st.addr));
    endproperty
    a_busy: assert property (p_busy) else $error("busy did not freeze");

    property p_word;
        (advance && par && !cf_rise && !MEM_WR_EN) |=> (st.data == mem[st.addr]);
    endproperty
    a_word: assert property (p_word) else $error("word not presented");

    property p_cf_block;
        (!cf_in && active) |=> ($stable(st.addr) && $stable(st.bit_idx));
    endproperty
    a_cf_block: assert property (p_cf_block) else $error("step while pulse pin low");

    property p_osc_step;
        (!sel_ext && int_tick && active && cf_in && !busy && st.por_done)
            |=> FORWARDED_CONFIG_CLOCK;
    endproperty
    a_osc_step: assert property (p_osc_step) else $error("oscillator tick lost");

    property p_ser_step;
        (advance && !par && !cf_rise && st.bit_idx != BIT_LAST)
            |=> (st.bit_idx == cpr_pkg::BIT_W'($past(st.bit_idx) + 1) && $stable(st.addr));
    endproperty
    a_ser_step: assert property (p_ser_step) else $error("serial bit not stepped");

    // Requests inside a pulse are dropped, not queued
    property p_reload_busy;
        CONFIG_PULSE_N_OE |=> (st.pulse_cnt == cpr_pkg::CNT_W'($past(st.pulse_cnt) - 1));
    endproperty
    a_reload_busy: assert property (p_reload_busy) else $error("reload not ignored");

    c_par_step:    cover property (advance && par);
    c_ser_step:    cover property (advance && !par);
    c_busy_stall:  cover property (par && busy && src_tick && active);
    c_rev_reload:  cover property (cf_rise && active);
    c_pulse:       cover property ($fell(CONFIG_PULSE_N_OE));
endmodule // cpr_readout
`default_nettype wire

// file: verification/cpr_fpga_model.sv
// Model of the FPGA configuration port at the far end of the readout.
// Assumes the bench calls its tasks just after a CLK_SYS rising edge.
`timescale 1ns/1ns
`default_nettype none
module cpr_fpga_model (
    input  wire logic clk_sys,
    output logic      cfg_clk,
    output logic      busy
);
    initial begin
        cfg_clk = 1'b0;
        busy = 1'b0;
    end
    // One 30 ns period per call, then the clock stands still.
    // Spaced edges keep the synchroniser from merging them.
    task automatic clk_edge();
        cfg_clk = 1'b1;
        #15;
        cfg_clk = 1'b0;
        #15;
        repeat (8) @(posedge clk_sys);
        #1;
    endtask
    task automatic set_busy(input logic b);
        @(posedge clk_sys);
        #1;
        busy = b;
    endtask
endmodule // cpr_fpga_model
`default_nettype wire

// file: verification/cpr_readout_tb_top.sv
// Self-checking bench for the configuration readout control.
// Assumes open-drain pins pulled high; the bench resolves their level.
`timescale 1ns/1ns
`default_nettype none
module cpr_readout_tb_top;
    logic       clk_sys, arst_n, cs_n, oe_low, pulse_low, isp, clamp, ext, par, jtag, wr_en;
    logic [1:0] rev;
    logic [7:0] wr_addr, wr_data;
    logic       dq0, dq0_oe, fclk, fclk_oe, standby, oe_rst_oe, pulse_oe, oe_rst_out, pulse_out;
    logic [6:0] dq_hi, dq_hi_oe;
    wire        cfg_clk, busy, oe_pin, pulse_pin;
    int         n_mismatch, samples_checked;
    int         n_fclk = 0;
    // Open-drain wires: anyone pulling wins, else the pull-up
    assign oe_pin = !(oe_low || (oe_rst_oe && !oe_rst_out));
    assign pulse_pin = !(pulse_low || (pulse_oe && !pulse_out));

    cpr_fpga_model fpga (.clk_sys(clk_sys), .cfg_clk(cfg_clk), .busy(busy));
    cpr_readout dut (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CFG_CLK(cfg_clk), .CHIP_SELECT_N(cs_n),
        .OE_RESET_IN(oe_pin), .OE_RESET_OUT(oe_rst_out), .OE_RESET_OE(oe_rst_oe),
        .CONFIG_PULSE_N_IN(pulse_pin), .CONFIG_PULSE_N_OUT(pulse_out),
        .CONFIG_PULSE_N_OE(pulse_oe),
        .BUSY(busy), .IN_SYSTEM_PROGRAM_MODE(isp), .PINS_CLAMPED(clamp),
        .CLOCK_SELECT_EXTERNAL(ext), .PARALLEL_MODE(par), .REVISION_SELECT(rev),
        .JTAG_RELOAD(jtag), .MEM_WR_EN(wr_en), .MEM_WR_ADDR(wr_addr), .MEM_WR_DATA(wr_data),
        .SERIAL_DATA_BIT(dq0), .SERIAL_DATA_BIT_OE(dq0_oe), .UPPER_PARALLEL_DATA_BITS(dq_hi),
        .UPPER_PARALLEL_DATA_BITS_OE(dq_hi_oe), .FORWARDED_CONFIG_CLOCK(fclk),
        .FORWARDED_CONFIG_CLOCK_OE(fclk_oe), .STANDBY(standby));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // Clock pulses counted mid-cycle, away from the edge that launches them
    always @(negedge clk_sys) begin
        if (fclk === 1'b1) n_fclk++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Stored pattern: neighbouring words always differ
    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ {a[3:0], 4'h9};
    endfunction
    function automatic logic [7:0] word();
        return {dq_hi, dq0};
    endfunction
    function automatic logic [7:0] oes();
        return {dq_hi_oe, dq0_oe};
    endfunction
    // Steps so far: counted pulses plus one still standing after the edge
    function automatic int steps();
        return n_fclk + ((fclk === 1'b1) ? 1 : 0);
    endfunction

    task automatic t_por();
        cyc(5);
        check("por_hold", 8'h01, {7'h0, oe_rst_oe});
        cyc(20);
        check("por_release", 8'h00, {7'h0, oe_rst_oe});
    endtask
    task automatic t_fill();
        wr_en = 1'b1;
        for (int a = 0; a < 256; a++) begin
            wr_addr = a[7:0];
            wr_data = pat(a[7:0]);
            cyc(1);
        end
        wr_en = 1'b0;
        cyc(2);
    endtask
    task automatic t_par();
        int s;
        s = steps();
        for (int k = 1; k <= 3; k++) begin
            fpga.clk_edge();
            check("par_word", pat(k[7:0]), word());
        end
        check("par_pulses", 8'h03, 8'(steps() - s));
        check("par_oe", 8'hff, oes());
        fpga.set_busy(1'b1);
        cyc(4);
        s = steps();
        fpga.clk_edge();
        check("busy_hold", pat(8'h03), word());
        check("busy_pulses", 8'h00, 8'(steps() - s));
        fpga.set_busy(1'b0);
        cyc(4);
        fpga.clk_edge();
        check("busy_next", pat(8'h04), word());
    endtask
    task automatic t_gate();
        int s;
        rev = 2'd1;
        pulse_low = 1'b1;
        cyc(5);
        fpga.clk_edge();
        check("pulse_block", pat(8'h04), word());
        pulse_low = 1'b0;
        cyc(5);
        check("rev_load", pat(8'h40), word());
        rev = 2'd0;
        cyc(5);
        fpga.clk_edge();
        check("rev_held", pat(8'h41), word());
        ext = 1'b0;
        s = steps();
        cyc(20);
        // 18 decisions on the oscillator, one tick in four
        check("osc_run", 8'h01, {7'h0, (steps() - s) inside {4, 5}});
        check("osc_word", pat(8'h41 + 8'(steps() - s)), word());
        ext = 1'b1;
        cyc(5);
    endtask
    // Counter restarts at the held revision, 0x40
    task automatic t_off(input logic use_cs);
        int s;
        if (use_cs) cs_n = 1'b1;
        else oe_low = 1'b1;
        cyc(5);
        check("off_data_oe", 8'h00, oes());
        check("off_clk_oe", 8'h00, {7'h0, fclk_oe});
        check("standby", {7'h0, use_cs}, {7'h0, standby});
        s = steps();
        fpga.clk_edge();
        check("off_steps", 8'h00, 8'(steps() - s));
        cs_n = 1'b0;
        oe_low = 1'b0;
        cyc(5);
        fpga.clk_edge();
        check("restart", pat(8'h41), word());
    endtask
    task automatic t_serial();
        logic [7:0] w;
        par = 1'b0;
        pulse_low = 1'b1;
        cyc(5);
        pulse_low = 1'b0;
        cyc(5);
        check("ser_oe", 8'h01, oes());
        for (int k = 0; k < 10; k++) begin
            w = pat(8'(k / 8));
            check("ser_bit", {7'h0, w[7 - k % 8]}, {7'h0, dq0});
            fpga.clk_edge();
        end
        par = 1'b1;
        cyc(5);
    endtask
    task automatic t_isp();
        isp = 1'b1;
        cyc(5);
        check("isp_float", 8'h00, oes());
        clamp = 1'b1;
        cyc(5);
        check("isp_clamped", 8'hff, oes());
        isp = 1'b0;
        clamp = 1'b0;
        cyc(5);
    endtask
    // Pulse starts on the edge after the request and stands ten cycles
    task automatic t_jtag();
        jtag = 1'b1;
        cyc(1);
        jtag = 1'b0;
        cyc(1);
        check("reload_start", 8'h01, {7'h0, pulse_oe});
        cyc(8);
        check("reload_hold", 8'h01, {7'h0, pulse_oe});
        cyc(1);
        check("reload_end", 8'h00, {7'h0, pulse_oe});
    endtask

    task automatic tally_and_finish();
        $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        {arst_n, cs_n, oe_low, pulse_low, isp, clamp, par, jtag, wr_en} = '0;
        ext = 1'b1;
        rev = 2'd0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        n_mismatch = 0;
        samples_checked = 0;
        par = 1'b1;
        cyc(10);
        arst_n = 1'b1;
        t_por();
        t_fill();
        t_par();
        t_gate();
        t_off(1'b1);
        t_off(1'b0);
        t_serial();
        t_isp();
        t_jtag();
        tally_and_finish();
    end
endmodule // cpr_readout_tb_top
`default_nettype wire
